// ---- rtl/wdrc_pkg.sv ----
// =====================================================================
// What this block does
// - watchdog counts sub clock, source selectable
// - period select sets timeout in sub-clock periods
// - key 10101 disables, 01010 enables watchdog
// - other key codes reset after soft delay
// - invalid key reset sets watchdog key flag
// - watchdog key flag cleared only by software
// - enable key powers up as 01010
// - running overflow resets device, sets timeout flag
// - sleep overflow sets timeout, resets PC, SP
// - counter cleared by key reset, clear, halt
// - power-on reset zeroes program counter
// - power-on sets port data, direction all ones
// - brownout on unless power-down, resets, sets event flag
// - brownout needs low longer than filter time
// - level select accepts four defined codes
// - other level code resets, reloads 01010101
// - genuine brownout keeps level select contents
// - bad level code sets flag, software clears
// - brownout reset sets event flag, software clears
// - brownout disabled during power-down mode
// - control bits six to four read zero
// - idle or sleep entry clears counter
// - sleep timeout leaves timeout, power-down set
package wdrc_pkg;

  // =====================================================================
  // register offsets (byte addresses)
  localparam logic [11:0] WDRC_OFS_WDOG_CTRL  = 12'h000;
  localparam logic [11:0] WDRC_OFS_FLAG_CTRL  = 12'h004;
  localparam logic [11:0] WDRC_OFS_LEVEL_SEL  = 12'h008;
  localparam logic [11:0] WDRC_OFS_SUBCLK_CFG = 12'h00C;
  localparam logic [11:0] WDRC_OFS_STATUS     = 12'h010;
  localparam logic [11:0] WDRC_OFS_PORT       = 12'h014;

  // =====================================================================
  // field positions
  localparam int WDRC_KEY_LSB       = 3;
  localparam int WDRC_FLG_IDLE_KEEP = 7;
  localparam int WDRC_FLG_SUBCLK    = 3;
  localparam int WDRC_FLG_BROWNOUT  = 2;
  localparam int WDRC_FLG_LEVEL_KEY = 1;
  localparam int WDRC_FLG_WDOG_KEY  = 0;
  localparam int WDRC_SUBCLK_SEL    = 0;

  // =====================================================================
  // codes and reset values
  localparam logic [4:0] WDRC_KEY_DISABLE   = 5'h15;
  localparam logic [4:0] WDRC_KEY_ENABLE    = 5'h0A;
  localparam logic [7:0] WDRC_WDOG_CTRL_POR = 8'h53;
  localparam logic [7:0] WDRC_LEVEL_2V10    = 8'h55;
  localparam logic [7:0] WDRC_LEVEL_2V55    = 8'h33;
  localparam logic [7:0] WDRC_LEVEL_3V15    = 8'h99;
  localparam logic [7:0] WDRC_LEVEL_3V80    = 8'hAA;
  localparam logic [7:0] WDRC_LEVEL_POR     = 8'h55;
  localparam logic [7:0] WDRC_SUBCLK_POR    = 8'h2A;
  localparam logic [7:0] WDRC_PORT_POR      = 8'hFF;
  localparam logic [7:0] WDRC_FLAG_POR      = 8'h00;

  // =====================================================================
  // timing
  localparam int WDRC_CLK_MHZ            = 125;
  localparam int WDRC_SOFT_RESET_DELAY_NS = 1000;
  localparam int WDRC_BO_FILTER_TIME_NS   = 1000;
  localparam int WDRC_SOFT_RESET_CYCLES   =
    (WDRC_SOFT_RESET_DELAY_NS * WDRC_CLK_MHZ + 999) / 1000;
  localparam int WDRC_BO_FILTER_CYCLES    =
    (WDRC_BO_FILTER_TIME_NS * WDRC_CLK_MHZ + 999) / 1000;

  // =====================================================================
  // carriers
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } wdrc_apb_req_s;

  typedef struct packed {
    logic clear_watchdog_instr;
    logic halt_instr;
    logic low_power;
    logic power_down;
  } wdrc_cpu_s;

endpackage

// ---- rtl/wdrc_top.sv ----
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps
module wdrc_top
  import wdrc_pkg::*;
#(
  parameter int SOFT_RESET_CYCLES = WDRC_SOFT_RESET_CYCLES,
  parameter int BO_FILTER_CYCLES  = WDRC_BO_FILTER_CYCLES,
  parameter int CNT_W             = 19
) (
  input  wire logic          clk_i,
  input  wire logic          rst_b_i,
  input  wire wdrc_apb_req_s apb_i,
  output logic               pready_o,
  output logic [31:0]        prdata_o,
  output logic               pslverr_o,
  input  wire wdrc_cpu_s     cpu_i,
  input  wire logic          low_speed_rc_osc_i,
  input  wire logic          low_speed_crystal_osc_i,
  input  wire logic          brownout_low_i,
  input  wire logic          subclk_cfg_fault_i,
  output logic               sys_reset_o,
  output logic               pc_sp_reset_o,
  output logic               timeout_status_flag_o,
  output logic               powerdown_status_flag_o,
  output logic [7:0]         brownout_threshold_o,
  output logic               idle_sysclk_keep_o,
  output logic [7:0]         port_data_o,
  output logic [7:0]         port_dir_o
);

  // =====================================================================
  // declarations
  logic [7:0]       wdog_ctrl_q;
  logic [7:0]       flag_ctrl_q;
  logic [7:0]       level_sel_q;
  logic [7:0]       subclk_cfg_q;
  logic [7:0]       port_data_q;
  logic [7:0]       port_dir_q;
  logic [1:0]       osc_meta_q;
  logic [1:0]       osc_sync_q;
  logic             sub_clock_q;
  logic             sub_clock;
  logic             sub_tick;
  logic [1:0]       bo_sync_q;
  logic [31:0]      bo_cnt_q;
  logic             bo_done_q;
  logic [CNT_W-1:0] wdog_cnt_q;
  logic [CNT_W-1:0] wdog_limit;
  logic [4:0]       wdog_enable_key;
  logic [2:0]       wdog_period_sel;
  logic             wdog_on;
  logic [1:0]       key_bad;
  logic [1:0]       key_fire;
  logic             level_ok;
  logic             wdog_ovf;
  logic             ovf_run;
  logic             ovf_sleep;
  logic             bo_fire;
  logic             dev_reset;
  logic             wr_en;
  logic             setup;
  logic [7:0]       wr_byte;
  logic             to_q;
  logic             pdf_q;
  logic             sys_reset_q;
  logic             pc_sp_reset_q;
  logic             pready_q;
  logic             pslverr_q;
  logic [31:0]      prdata_q;
  logic [31:0]      rd_data;
  logic             rd_hit;

  assign wdog_enable_key = wdog_ctrl_q[WDRC_KEY_LSB +: 5];
  assign wdog_period_sel = wdog_ctrl_q[2:0];
  assign wdog_on         = (wdog_enable_key == WDRC_KEY_ENABLE);

  // =====================================================================
  // sub clock: synchronise both oscillators, select, detect rising edge
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_osc
      always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          osc_meta_q[g] <= 1'b0;
          osc_sync_q[g] <= 1'b0;
        end else begin
          osc_meta_q[g] <= (g == 0) ? low_speed_rc_osc_i : low_speed_crystal_osc_i;
          osc_sync_q[g] <= osc_meta_q[g];
        end
      end
    end
  endgenerate

  // source chosen by the subclock configuration register
  assign sub_clock = subclk_cfg_q[WDRC_SUBCLK_SEL] ? osc_sync_q[1] : osc_sync_q[0];
  assign sub_tick  = sub_clock & ~sub_clock_q;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sub_clock_q <= 1'b0;
    end else begin
      sub_clock_q <= sub_clock;
    end
  end

  // =====================================================================
  // timeout limit from period select
  always_comb begin
    unique case (wdog_period_sel)
      3'h0:    wdog_limit = CNT_W'(19'h00100);
      3'h1:    wdog_limit = CNT_W'(19'h00400);
      3'h2:    wdog_limit = CNT_W'(19'h01000);
      3'h3:    wdog_limit = CNT_W'(19'h04000);
      3'h4:    wdog_limit = CNT_W'(19'h08000);
      3'h5:    wdog_limit = CNT_W'(19'h10000);
      3'h6:    wdog_limit = CNT_W'(19'h20000);
      3'h7:    wdog_limit = CNT_W'(19'h40000);
    endcase
  end

  // =====================================================================
  // reset sources
  assign level_ok = (level_sel_q == WDRC_LEVEL_2V10) || (level_sel_q == WDRC_LEVEL_2V55) ||
                    (level_sel_q == WDRC_LEVEL_3V15) || (level_sel_q == WDRC_LEVEL_3V80);
  assign key_bad[0] = (wdog_enable_key != WDRC_KEY_ENABLE) &&
                      (wdog_enable_key != WDRC_KEY_DISABLE);
  assign key_bad[1] = ~level_ok;

  assign wdog_ovf  = wdog_on && sub_tick && (wdog_cnt_q == wdog_limit - CNT_W'(1));
  assign ovf_run   = wdog_ovf && !cpu_i.low_power;
  assign ovf_sleep = wdog_ovf && cpu_i.low_power;
  assign dev_reset = ovf_run | key_fire[0] | key_fire[1] | bo_fire;

  // delayed software resets for bad watchdog key and bad level code
  generate
    for (g = 0; g < 2; g++) begin : g_key
      logic [31:0] dly_q;
      assign key_fire[g] = key_bad[g] && (dly_q == 32'(SOFT_RESET_CYCLES - 1));
      always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          dly_q <= 32'h00000000;
        end else if (!key_bad[g] || dev_reset) begin
          dly_q <= 32'h00000000;
        end else begin
          dly_q <= dly_q + 32'h00000001;
        end
      end
    end
  endgenerate

  // brownout filter: low must persist past the filter time
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bo_sync_q <= 2'b00;
    end else begin
      bo_sync_q <= {bo_sync_q[0], brownout_low_i};
    end
  end

  assign bo_fire = bo_sync_q[1] && !cpu_i.power_down && !bo_done_q &&
                   (bo_cnt_q == 32'(BO_FILTER_CYCLES - 1));

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bo_cnt_q  <= 32'h00000000;
      bo_done_q <= 1'b0;
    end else if (!bo_sync_q[1] || cpu_i.power_down) begin
      bo_cnt_q  <= 32'h00000000;
      bo_done_q <= 1'b0;
    end else if (bo_fire) begin
      bo_done_q <= 1'b1;
    end else if (!bo_done_q) begin
      bo_cnt_q  <= bo_cnt_q + 32'h00000001;
    end
  end

  // =====================================================================
  // watchdog counter
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wdog_cnt_q <= '0;
    end else if (dev_reset || cpu_i.clear_watchdog_instr || cpu_i.halt_instr ||
                 wdog_ovf) begin
      wdog_cnt_q <= '0;
    end else if (wdog_on && sub_tick) begin
      wdog_cnt_q <= wdog_cnt_q + CNT_W'(1);
    end
  end

  // =====================================================================
  // reset and status outputs
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sys_reset_q   <= 1'b1;
      pc_sp_reset_q <= 1'b1;
    end else begin
      sys_reset_q   <= dev_reset;
      pc_sp_reset_q <= dev_reset | ovf_sleep;
    end
  end

  // timeout and power-down flags
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      to_q  <= 1'b0;
      pdf_q <= 1'b0;
    end else if (wdog_ovf) begin
      to_q  <= 1'b1;
    end else if (cpu_i.halt_instr) begin
      to_q  <= 1'b0;
      pdf_q <= 1'b1;
    end else if (cpu_i.clear_watchdog_instr) begin
      to_q  <= 1'b0;
      pdf_q <= 1'b0;
    end
  end

  // =====================================================================
  // apb slave: one wait-free access phase
  assign setup   = apb_i.psel && !apb_i.penable;
  assign wr_en   = apb_i.psel && apb_i.penable && pready_q && apb_i.pwrite;
  assign wr_byte = apb_i.pwdata[7:0];

  always_comb begin
    rd_hit  = 1'b1;
    rd_data = 32'h00000000;
    unique case (apb_i.paddr)
      WDRC_OFS_WDOG_CTRL:  rd_data[7:0]  = wdog_ctrl_q;
      WDRC_OFS_FLAG_CTRL:  rd_data[7:0]  = flag_ctrl_q & 8'h8F;
      WDRC_OFS_LEVEL_SEL:  rd_data[7:0]  = level_sel_q;
      WDRC_OFS_SUBCLK_CFG: rd_data[7:0]  = subclk_cfg_q;
      WDRC_OFS_STATUS:     rd_data[2:0]  = {wdog_on, pdf_q, to_q};
      WDRC_OFS_PORT:       rd_data[15:0] = {port_dir_q, port_data_q};
      default:             rd_hit        = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup && !rd_hit;
      prdata_q  <= (setup && !apb_i.pwrite) ? rd_data : 32'h00000000;
    end
  end

  // =====================================================================
  // watchdog control register
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wdog_ctrl_q <= WDRC_WDOG_CTRL_POR;
    end else if (dev_reset) begin
      wdog_ctrl_q <= WDRC_WDOG_CTRL_POR;
    end else if (wr_en && apb_i.paddr == WDRC_OFS_WDOG_CTRL) begin
      wdog_ctrl_q <= wr_byte;
    end
  end

  // level select: genuine brownout keeps it, other resets reload it
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      level_sel_q <= WDRC_LEVEL_POR;
    end else if (ovf_run || key_fire[0] || key_fire[1]) begin
      level_sel_q <= WDRC_LEVEL_POR;
    end else if (bo_fire) begin
      level_sel_q <= level_sel_q;
    end else if (wr_en && apb_i.paddr == WDRC_OFS_LEVEL_SEL) begin
      level_sel_q <= wr_byte;
    end
  end

  // sticky reset-cause flags: hardware set wins over software clear
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flag_ctrl_q <= WDRC_FLAG_POR;
    end else begin
      if (dev_reset) begin
        flag_ctrl_q[WDRC_FLG_IDLE_KEEP] <= 1'b0;
      end else if (wr_en && apb_i.paddr == WDRC_OFS_FLAG_CTRL) begin
        flag_ctrl_q[WDRC_FLG_IDLE_KEEP] <= wr_byte[WDRC_FLG_IDLE_KEEP];
      end
      for (int i = 0; i < 4; i++) begin
        if (wr_en && apb_i.paddr == WDRC_OFS_FLAG_CTRL && !wr_byte[i]) begin
          flag_ctrl_q[i] <= 1'b0;
        end
      end
      if (key_fire[0]) begin
        flag_ctrl_q[WDRC_FLG_WDOG_KEY] <= 1'b1;
      end
      if (key_fire[1]) begin
        flag_ctrl_q[WDRC_FLG_LEVEL_KEY] <= 1'b1;
      end
      if (bo_fire) begin
        flag_ctrl_q[WDRC_FLG_BROWNOUT] <= 1'b1;
      end
      if (subclk_cfg_fault_i) begin
        flag_ctrl_q[WDRC_FLG_SUBCLK] <= 1'b1;
      end
    end
  end

  // subclock configuration
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      subclk_cfg_q <= WDRC_SUBCLK_POR;
    end else if (dev_reset) begin
      subclk_cfg_q <= WDRC_SUBCLK_POR;
    end else if (wr_en && apb_i.paddr == WDRC_OFS_SUBCLK_CFG) begin
      subclk_cfg_q <= wr_byte;
    end
  end

  // port data and direction: inputs after any full reset
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      port_data_q <= WDRC_PORT_POR;
      port_dir_q  <= WDRC_PORT_POR;
    end else if (dev_reset) begin
      port_data_q <= WDRC_PORT_POR;
      port_dir_q  <= WDRC_PORT_POR;
    end else if (wr_en && apb_i.paddr == WDRC_OFS_PORT) begin
      port_data_q <= apb_i.pwdata[7:0];
      port_dir_q  <= apb_i.pwdata[15:8];
    end
  end

  // =====================================================================
  // outputs
  assign pready_o                = pready_q;
  assign prdata_o                = prdata_q;
  assign pslverr_o               = pslverr_q;
  assign sys_reset_o             = sys_reset_q;
  assign pc_sp_reset_o           = pc_sp_reset_q;
  assign timeout_status_flag_o   = to_q;
  assign powerdown_status_flag_o = pdf_q;
  assign brownout_threshold_o    = level_sel_q;
  assign idle_sysclk_keep_o      = flag_ctrl_q[WDRC_FLG_IDLE_KEEP];
  assign port_data_o             = port_data_q;
  assign port_dir_o              = port_dir_q;

endmodule

// ---- verification/wdrc_properties.sv ----
`timescale 1ns/1ps
module wdrc_checker
  import wdrc_pkg::*;
#(
  parameter int SOFT_RESET_CYCLES = 4,
  parameter int BO_FILTER_CYCLES  = 4,
  parameter int CNT_W             = 19
) (
  input wire logic          clk_i,
  input wire logic          rst_b_i,
  input wire wdrc_apb_req_s apb_i,
  input wire logic          pready_o,
  input wire logic [31:0]   prdata_o,
  input wire logic          pslverr_o,
  input wire wdrc_cpu_s     cpu_i,
  input wire logic          low_speed_rc_osc_i,
  input wire logic          low_speed_crystal_osc_i,
  input wire logic          brownout_low_i,
  input wire logic          subclk_cfg_fault_i,
  input wire logic          sys_reset_o,
  input wire logic          pc_sp_reset_o,
  input wire logic          timeout_status_flag_o,
  input wire logic          powerdown_status_flag_o,
  input wire logic [7:0]    brownout_threshold_o,
  input wire logic          idle_sysclk_keep_o,
  input wire logic [7:0]    port_data_o,
  input wire logic [7:0]    port_dir_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  // =====================================================================
  // register bus
  apb_ready_a: assert property (apb_i.psel && !apb_i.penable |=> pready_o)
    else $error("no ready after setup");
  ctrl_unimpl_a: assert property (pready_o && !apb_i.pwrite && apb_i.paddr == 12'h004
    |-> prdata_o[6:4] == 3'h0) else $error("control bits 6..4 not zero");

  // =====================================================================
  // reset outputs
  sys_pulse_a: assert property ($rose(sys_reset_o) |=> !sys_reset_o)
    else $error("device reset longer than one cycle");
  full_pcsp_a: assert property (sys_reset_o |-> pc_sp_reset_o)
    else $error("full reset without counter reset");
  port_reload_a: assert property (sys_reset_o |=> port_data_o == 8'hFF && port_dir_o == 8'hFF)
    else $error("ports not all ones after reset");
  to_cause_a: assert property ($rose(timeout_status_flag_o) |-> ##[0:2] pc_sp_reset_o)
    else $error("timeout flag without reset");
  pdf_cause_a: assert property ($rose(powerdown_status_flag_o)
    |-> $past(cpu_i.halt_instr) || $past(cpu_i.halt_instr, 2)) else $error("power-down flag without halt");
  level_hold_a: assert property (!$stable(brownout_threshold_o) |-> sys_reset_o ||
    $past(pready_o && apb_i.pwrite && apb_i.paddr == 12'h008)) else $error("level changed alone");
endmodule

bind wdrc_top wdrc_checker #(
  .SOFT_RESET_CYCLES(SOFT_RESET_CYCLES), .BO_FILTER_CYCLES(BO_FILTER_CYCLES), .CNT_W(CNT_W)
) chk_u (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .apb_i(apb_i), .pready_o(pready_o),
  .prdata_o(prdata_o), .pslverr_o(pslverr_o), .cpu_i(cpu_i),
  .low_speed_rc_osc_i(low_speed_rc_osc_i), .low_speed_crystal_osc_i(low_speed_crystal_osc_i),
  .brownout_low_i(brownout_low_i), .subclk_cfg_fault_i(subclk_cfg_fault_i),
  .sys_reset_o(sys_reset_o), .pc_sp_reset_o(pc_sp_reset_o),
  .timeout_status_flag_o(timeout_status_flag_o),
  .powerdown_status_flag_o(powerdown_status_flag_o),
  .brownout_threshold_o(brownout_threshold_o), .idle_sysclk_keep_o(idle_sysclk_keep_o),
  .port_data_o(port_data_o), .port_dir_o(port_dir_o)
);

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
module testbench
  import wdrc_pkg::*;
;
  logic          clk_i = 1'b0, rst_b_i = 1'b0, rc = 1'b0, xt = 1'b0, bo = 1'b0, sf = 1'b0;
  wdrc_apb_req_s apb_i = '0;
  wdrc_cpu_s     cpu_i = '0;
  logic          pready_o, pslverr_o, sys_o, pcsp_o, to_o, pdf_o, keep_o, er, gs, gp;
  logic [31:0]   prdata_o, rd;
  logic [7:0]    thr_o, pd_o, pdir_o, lf = 8'h5A;
  logic [3:0]    div = '0;
  int            err_count = 0, tests_run = 0, ticks = 0, cyc = 0, t0;

  // =====================================================================
  // clock, slow oscillators with a tick count, run limit
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    div <= div + 4'h1;
    rc <= div[1];
    xt <= div[2];
    if (div[1:0] == 2'h2) ticks <= ticks + 1;
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      tally_and_finish();
    end
  end

  wdrc_top #(.SOFT_RESET_CYCLES(4), .BO_FILTER_CYCLES(4), .CNT_W(19)) dut_u (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .apb_i(apb_i), .pready_o(pready_o),
    .prdata_o(prdata_o), .pslverr_o(pslverr_o), .cpu_i(cpu_i),
    .low_speed_rc_osc_i(rc), .low_speed_crystal_osc_i(xt), .brownout_low_i(bo),
    .subclk_cfg_fault_i(sf), .sys_reset_o(sys_o), .pc_sp_reset_o(pcsp_o),
    .timeout_status_flag_o(to_o), .powerdown_status_flag_o(pdf_o),
    .brownout_threshold_o(thr_o), .idle_sysclk_keep_o(keep_o),
    .port_data_o(pd_o), .port_dir_o(pdir_o)
  );

  // =====================================================================
  // helpers
  function automatic logic [7:0] nx(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ck1(input logic got, input logic exp);
    check({31'h0, got}, {31'h0, exp});
  endtask
  // one apb transfer, held until ready
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    apb_i <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_i);
    apb_i.penable <= 1'b1;
    // no local limit: only the run limit ends a stalled transfer
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    apb_i <= '0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  // one-cycle pulse, started after an edge so back-to-back calls stay apart
  task automatic clr();
    @(posedge clk_i);
    cpu_i.clear_watchdog_instr <= 1'b1;
    @(posedge clk_i);
    cpu_i.clear_watchdog_instr <= 1'b0;
  endtask
  // wait for a reset pulse, bounded
  task automatic wait_rst(input int lim);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (sys_o !== 1'b1 && pcsp_o !== 1'b1 && n < lim);
    gs = sys_o;
    gp = pcsp_o;
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // =====================================================================
  // main sequence
  initial begin
    logic [11:0] oa [6];
    logic [31:0] ev [6];
    logic [7:0]  lv [4];
    int          lim [2];
    oa = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h014, 12'h018};
    ev = '{32'h53, 32'h0, 32'h55, 32'h2A, 32'hFFFF, 32'h0};
    lv = '{WDRC_LEVEL_2V10, WDRC_LEVEL_2V55, WDRC_LEVEL_3V15, WDRC_LEVEL_3V80};
    lim = '{256, 1024};
    repeat (6) @(posedge clk_i);
    rst_b_i <= 1'b1;
    // reset values and the unmapped hole
    for (int i = 0; i < 6; i++) begin
      rdchk(oa[i], ev[i]);
      ck1(er, 1'(i == 5));
    end
    // flag set by hardware, ones ignored, zero clears
    sf <= 1'b1;
    @(posedge clk_i);
    sf <= 1'b0;
    rdchk(12'h004, 32'h08);
    wr(12'h004, 32'hF7);
    rdchk(12'h004, 32'h80);
    ck1(keep_o, 1'b1);
    wr(12'h004, 32'h0);
    foreach (lv[i]) begin
      wr(12'h008, {24'h0, lv[i]});
      rdchk(12'h008, {24'h0, lv[i]});
      check({24'h0, thr_o}, {24'h0, lv[i]});
    end
    lf = nx(lf);
    wr(12'h014, {16'h0, ~lf, lf});
    @(posedge clk_i);
    ck1(pd_o === lf && pdir_o === ~lf, 1'b1);
    // undefined level code
    do lf = nx(lf); while (lf inside {8'h55, 8'h33, 8'h99, 8'hAA});
    wr(12'h008, {24'h0, lf});
    wait_rst(50);
    ck1(gs, 1'b1);
    rdchk(12'h008, {24'h0, WDRC_LEVEL_POR});
    rdchk(12'h004, 32'h02);
    wr(12'h004, 32'h0);
    // undefined enable key
    do lf = nx(lf); while (lf[4:0] inside {WDRC_KEY_DISABLE, WDRC_KEY_ENABLE});
    wr(12'h000, {24'h0, lf[4:0], 3'h3});
    wait_rst(50);
    ck1(gs, 1'b1);
    rdchk(12'h000, {24'h0, WDRC_WDOG_CTRL_POR});
    rdchk(12'h004, 32'h01);
    wr(12'h004, 32'h0);
    // disabled watchdog stays quiet
    wr(12'h000, {24'h0, WDRC_KEY_DISABLE, 3'h0});
    wait_rst(2400);
    ck1(gs, 1'b0);
    rdchk(12'h010, 32'h0);
    // regular clears hold off the overflow
    clr();
    wr(12'h000, {24'h0, WDRC_KEY_ENABLE, 3'h0});
    repeat (6) begin
      wait_rst(800);
      ck1(gs, 1'b0);
      clr();
    end
    // overflow period in ticks
    for (int c = 0; c < 2; c++) begin
      clr();
      t0 = ticks;
      wr(12'h000, {24'h0, WDRC_KEY_ENABLE, c[2:0]});
      wait_rst(10000);
      ck1(gs, 1'b1);
      ck1(1'(ticks - t0 >= lim[c] - 1 && ticks - t0 <= lim[c] + 1), 1'b1);
      ck1(to_o, 1'b1);
    end
    // crystal source: eight clocks per tick, so 256 ticks span about 2048 clocks
    wr(12'h00C, 32'h2B);
    wr(12'h000, {24'h0, WDRC_KEY_ENABLE, 3'h0});
    clr();
    t0 = cyc;
    wait_rst(4000);
    ck1(gs, 1'b1);
    ck1(1'(cyc - t0 >= 2036 && cyc - t0 <= 2056), 1'b1);
    rdchk(12'h00C, {24'h0, WDRC_SUBCLK_POR});
    // overflow while asleep
    clr();
    wr(12'h000, {24'h0, WDRC_KEY_ENABLE, 3'h0});
    cpu_i.halt_instr <= 1'b1;
    @(posedge clk_i);
    cpu_i.halt_instr <= 1'b0;
    cpu_i.low_power <= 1'b1;
    wait_rst(3000);
    ck1(gp & ~gs, 1'b1);
    ck1(pdf_o, 1'b1);
    rdchk(12'h010, 32'h7);
    cpu_i.low_power <= 1'b0;
    clr();
    wr(12'h000, {24'h0, WDRC_KEY_DISABLE, 3'h0});
    rdchk(12'h010, 32'h0);
    // brownout filter, power-down, qualified reset
    wr(12'h008, {24'h0, WDRC_LEVEL_3V15});
    bo <= 1'b1;
    repeat (3) @(posedge clk_i);
    bo <= 1'b0;
    wait_rst(30);
    ck1(gs, 1'b0);
    cpu_i.power_down <= 1'b1;
    bo <= 1'b1;
    wait_rst(30);
    ck1(gs, 1'b0);
    cpu_i.power_down <= 1'b0;
    wait_rst(30);
    ck1(gs, 1'b1);
    bo <= 1'b0;
    rdchk(12'h008, {24'h0, WDRC_LEVEL_3V15});
    rdchk(12'h004, 32'h04);
    tally_and_finish();
  end
endmodule
